// >>> pkg/clock_fanout_pkg.sv
// constants, types and ratio decoding for the sixteen output clock fanout
`default_nettype none
package clock_fanout_pkg;

    // register map, byte addresses on the apb bus
    localparam int unsigned APB_ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control field layout and reset values
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_RATIO_LSB = 2;
    localparam int unsigned CTRL_W = 5;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [2:0] RATIO_RESET = 3'h1;

    // input period measurement, in system clock cycles
    localparam int unsigned PERIOD_W = 16;
    localparam logic [15:0] PERIOD_MAX = 16'hFFFF;

    // synthesiser widths
    localparam int unsigned NUM_W = 4;
    localparam int unsigned DEN_W = 3;
    localparam int unsigned LIMIT_W = PERIOD_W + DEN_W;
    localparam int unsigned ACC_W = LIMIT_W + 1;

    // group sizes
    localparam int unsigned LOW_GROUP_W = 4;
    localparam int unsigned FIXED_GROUP_W = 8;
    localparam int unsigned HIGH_GROUP_W = 4;

    typedef enum logic [1:0] {
        MODE_TRISTATE = 2'b00,
        MODE_TWELVE_FULL = 2'b01,
        MODE_EIGHT_FULL = 2'b10,
        MODE_ALL_FULL = 2'b11
    } output_mode_e;

    // ratio code 000: no synthesis, straight divide by two of the input
    localparam logic [2:0] RATIO_DIVIDER_ONLY = 3'h0;

    typedef struct packed {
        logic [2:0] ratio;
        output_mode_e mode;
    } fanout_ctrl_s;

    typedef struct packed {
        logic half_level;
        logic full_level;
        logic period_valid;
        logic [PERIOD_W-1:0] period;
    } fanout_status_s;

    // output/input ratio as numerator over denominator
    function automatic logic [NUM_W-1:0] ratio_num(input logic [2:0] code);
        unique case (code)
            3'h0: ratio_num = 4'h1;
            3'h1: ratio_num = 4'h1;
            3'h2: ratio_num = 4'h5;
            3'h3: ratio_num = 4'h2;
            3'h4: ratio_num = 4'h5;
            3'h5: ratio_num = 4'hA;
            3'h6: ratio_num = 4'h4;
            3'h7: ratio_num = 4'h5;
        endcase
    endfunction

    function automatic logic [DEN_W-1:0] ratio_den(input logic [2:0] code);
        unique case (code)
            3'h0: ratio_den = 3'h2;
            3'h1: ratio_den = 3'h1;
            3'h2: ratio_den = 3'h4;
            3'h3: ratio_den = 3'h1;
            3'h4: ratio_den = 3'h2;
            3'h5: ratio_den = 3'h3;
            3'h6: ratio_den = 3'h1;
            3'h7: ratio_den = 3'h1;
        endcase
    endfunction

endpackage
`default_nettype wire

// >>> hdl/rate_synth.sv
// full-rate clock synthesiser: phase accumulator locked to input rising edges
`timescale 1ns/1ps
`default_nettype none
module rate_synth
    import clock_fanout_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic in_rise_i,
    input wire logic [PERIOD_W-1:0] period_i,
    input wire logic period_valid_i,
    input wire logic [2:0] ratio_i,
    output logic full_o,
    output logic full_rise_o
);

    logic [ACC_W-1:0] acc;
    logic level;
    logic rise;
    logic bypass_level;
    logic [DEN_W-1:0] rise_cnt;

    wire logic bypass = (ratio_i == RATIO_DIVIDER_ONLY);
    wire logic [LIMIT_W-1:0] limit = LIMIT_W'(ratio_den(ratio_i)) * LIMIT_W'(period_i);
    wire logic [ACC_W-1:0] step = ACC_W'({ratio_num(ratio_i), 1'b0});
    wire logic [ACC_W-1:0] acc_sum = acc + step;
    wire logic wrap = (acc_sum >= ACC_W'(limit));
    wire logic [ACC_W-1:0] next_acc = wrap ? acc_sum - ACC_W'(limit) : acc_sum;
    wire logic [DEN_W-1:0] den = ratio_den(ratio_i);
    // output and input edges meet only once every den input periods, so realign only then;
    // realigning on every input edge would clip fractional ratios
    wire logic align = in_rise_i && (rise_cnt == 3'h0);
    wire logic [DEN_W-1:0] next_rise_cnt = (rise_cnt >= den - 3'h1) ? 3'h0 : rise_cnt + 3'h1;
    wire logic next_level = align ? 1'b1 : (wrap ? ~level : level);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            bypass_level <= 1'b0;
        end else if (in_rise_i) begin
            bypass_level <= ~bypass_level;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i || !period_valid_i) begin
            acc <= '0;
            level <= 1'b0;
            rise_cnt <= 3'h0;
        end else begin
            acc <= align ? '0 : next_acc;
            level <= next_level;
            rise_cnt <= in_rise_i ? next_rise_cnt : rise_cnt;
        end
    end

    wire logic synth_level = bypass ? bypass_level : level;
    wire logic next_synth = bypass ? (in_rise_i ? ~bypass_level : bypass_level)
                                   : (period_valid_i ? next_level : 1'b0);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rise <= 1'b0;
        end else begin
            rise <= next_synth & ~synth_level;
        end
    end

    assign full_o = synth_level;
    assign full_rise_o = rise;

endmodule // rate_synth
`default_nettype wire

// >>> hdl/clock_fanout.sv
// sixteen output clock fanout with mode and ratio control over apb
//
// Contract
// - mode bits choose tri-state or one of the full/half output groupings.
// - mode 11 drives all sixteen outputs at full rate.
// - mode 01: outputs 1-12 full rate, 13-16 half rate.
// - mode 10: outputs 5-12 full rate, 1-4 and 13-16 half rate.
// - mode 00 floats every clock output and the reference output.
// - outputs 5-12 always full rate unless floated.
// - outputs 1-4 full or half rate by mode.
// - outputs 13-16 full or half rate by mode.
// - reference output is a buffered copy of the input clock.
// - ratio code 000..111 gives 0.5, 1, 1.25, 2, 2.5, 3.333, 4, 5.
// - ratio code 000 divides the input by two without synthesis.
`timescale 1ns/1ps
`default_nettype none
module clock_fanout
    import clock_fanout_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic crystal_or_clock_in_i,
    output logic crystal_drive_out_o,
    output logic ref_o,
    output logic ref_oe_o,
    output logic [LOW_GROUP_W-1:0] switchable_group_low_o,
    output logic [LOW_GROUP_W-1:0] switchable_group_low_oe_o,
    output logic [FIXED_GROUP_W-1:0] fixed_full_rate_group_o,
    output logic [FIXED_GROUP_W-1:0] fixed_full_rate_group_oe_o,
    output logic [HIGH_GROUP_W-1:0] switchable_group_high_o,
    output logic [HIGH_GROUP_W-1:0] switchable_group_high_oe_o
);

    fanout_ctrl_s ctrl;
    fanout_status_s status;
    logic [31:0] rdata;
    logic in_prev;
    logic [PERIOD_W-1:0] count;
    logic [PERIOD_W-1:0] period;
    logic period_valid;
    logic half_level;
    logic ref_level;
    logic [LOW_GROUP_W-1:0] low_q;
    logic [FIXED_GROUP_W-1:0] fixed_q;
    logic [HIGH_GROUP_W-1:0] high_q;
    logic drive_q;
    logic full_level;
    logic full_rise;
    logic full_d;

    // apb decode
    wire logic setup = psel_i & ~penable_i;
    wire logic access = psel_i & penable_i;
    wire logic hit_ctrl = (paddr_i == CTRL_OFFSET);
    wire logic hit_status = (paddr_i == STATUS_OFFSET);
    wire logic hit = hit_ctrl | hit_status;
    wire logic ctrl_write = access & pwrite_i & hit_ctrl & pstrb_i[0];
    wire logic [31:0] next_rdata = hit_ctrl ? 32'(ctrl) : (hit_status ? 32'(status) : 32'h0);

    // zero wait states; unmapped addresses answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~hit;
    assign prdata_o = rdata;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ctrl <= '{ratio: RATIO_RESET, mode: output_mode_e'(MODE_RESET)};
        end else if (ctrl_write) begin
            ctrl <= fanout_ctrl_s'(pwdata_i[CTRL_W-1:0]);
        end
    end

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rdata <= 32'h0;
        end else if (setup) begin
            rdata <= next_rdata;
        end
    end

    // input edge detection and period measurement
    wire logic in_rise = crystal_or_clock_in_i & ~in_prev;
    wire logic [PERIOD_W-1:0] next_count = (count == PERIOD_MAX) ? count : count + 16'h1;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            in_prev <= 1'b0;
            count <= '0;
            period <= '0;
            period_valid <= 1'b0;
        end else begin
            in_prev <= crystal_or_clock_in_i;
            count <= in_rise ? 16'h1 : next_count;
            if (in_rise) begin
                period <= count;
                period_valid <= (count != 16'h0) && (count != PERIOD_MAX);
            end
        end
    end

    rate_synth u_rate_synth (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_rise_i(in_rise),
        .period_i(period),
        .period_valid_i(period_valid),
        .ratio_i(ctrl.ratio),
        .full_o(full_level),
        .full_rise_o(full_rise)
    );

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            half_level <= 1'b0;
            full_d <= 1'b0;
        end else begin
            // full delayed one cycle so half edges land on full edges
            full_d <= full_level;
            if (full_rise) begin
                half_level <= ~half_level;
            end
        end
    end

    assign status = '{half_level: half_level, full_level: full_level,
                      period_valid: period_valid, period: period};

    wire logic outputs_on = (ctrl.mode != MODE_TRISTATE);
    wire logic low_full = (ctrl.mode == MODE_ALL_FULL) || (ctrl.mode == MODE_TWELVE_FULL);
    wire logic high_full = (ctrl.mode == MODE_ALL_FULL);

    wire logic low_level = low_full ? full_d : half_level;
    wire logic high_level = high_full ? full_d : half_level;

    // data outputs registered so all groups see one equal delay
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            low_q <= '0;
            fixed_q <= '0;
            high_q <= '0;
            ref_level <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            low_q <= {LOW_GROUP_W{low_level}};
            fixed_q <= {FIXED_GROUP_W{full_d}};
            high_q <= {HIGH_GROUP_W{high_level}};
            ref_level <= crystal_or_clock_in_i;
            drive_q <= ~crystal_or_clock_in_i;
        end
    end

    assign switchable_group_low_o = low_q;
    assign fixed_full_rate_group_o = fixed_q;
    assign switchable_group_high_o = high_q;
    assign ref_o = ref_level;
    assign crystal_drive_out_o = drive_q;

    assign switchable_group_low_oe_o = {LOW_GROUP_W{outputs_on}};
    assign fixed_full_rate_group_oe_o = {FIXED_GROUP_W{outputs_on}};
    assign switchable_group_high_oe_o = {HIGH_GROUP_W{outputs_on}};
    assign ref_oe_o = outputs_on;

endmodule // clock_fanout
`default_nettype wire

// >>> verification/clock_fanout_properties.sv
// port assertions for the clock fanout
`timescale 1ns/1ps
`default_nettype none
module clock_fanout_properties
    import clock_fanout_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic crystal_or_clock_in_i,
    input wire logic ref_o,
    input wire logic ref_oe_o,
    input wire logic [LOW_GROUP_W-1:0] switchable_group_low_o,
    input wire logic [LOW_GROUP_W-1:0] switchable_group_low_oe_o,
    input wire logic [FIXED_GROUP_W-1:0] fixed_full_rate_group_o,
    input wire logic [FIXED_GROUP_W-1:0] fixed_full_rate_group_oe_o,
    input wire logic [HIGH_GROUP_W-1:0] switchable_group_high_o,
    input wire logic [HIGH_GROUP_W-1:0] switchable_group_high_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // edges glitch for a few cycles after a mode write, so edge checks wait
    logic [2:0] quiet;
    always_ff @(posedge clock_i) begin
        if (!resetn_i || (psel_i && penable_i && pwrite_i)) quiet <= 3'h0;
        else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
    property p_ref_copy;
        $past(resetn_i) |-> ref_o == $past(crystal_or_clock_in_i);
    endproperty
    a_ref_copy: assert property (p_ref_copy) else $error("ref not a copy of input");
    property p_oe_together;
        {switchable_group_low_oe_o, fixed_full_rate_group_oe_o, switchable_group_high_oe_o}
            == {16{ref_oe_o}};
    endproperty
    a_oe_together: assert property (p_oe_together) else $error("enables disagree");
    property p_fixed_same;
        fixed_full_rate_group_o == {8{fixed_full_rate_group_o[0]}};
    endproperty
    a_fixed_same: assert property (p_fixed_same) else $error("fixed group split");
    property p_low_same;
        switchable_group_low_o == {4{switchable_group_low_o[0]}};
    endproperty
    a_low_same: assert property (p_low_same) else $error("low group split");
    property p_high_same;
        switchable_group_high_o == {4{switchable_group_high_o[0]}};
    endproperty
    a_high_same: assert property (p_high_same) else $error("high group split");
    property p_high_rise;
        quiet == 3'h7 && $rose(switchable_group_high_o[0]) |-> $rose(fixed_full_rate_group_o[0]);
    endproperty
    a_high_rise: assert property (p_high_rise) else $error("high rise off edge");
    property p_low_rise;
        quiet == 3'h7 && $rose(switchable_group_low_o[0]) |-> $rose(fixed_full_rate_group_o[0]);
    endproperty
    a_low_rise: assert property (p_low_rise) else $error("low rise off edge");
    property p_high_toggle;
        quiet == 3'h7 && $changed(switchable_group_high_o[0])
            |-> $rose(fixed_full_rate_group_o[0]) ||
                switchable_group_high_o[0] == fixed_full_rate_group_o[0];
    endproperty
    a_high_toggle: assert property (p_high_toggle) else $error("half toggles off edge");
endmodule // clock_fanout_properties
bind clock_fanout clock_fanout_properties chk (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .crystal_or_clock_in_i(crystal_or_clock_in_i),
    .ref_o(ref_o),
    .ref_oe_o(ref_oe_o),
    .switchable_group_low_o(switchable_group_low_o),
    .switchable_group_low_oe_o(switchable_group_low_oe_o),
    .fixed_full_rate_group_o(fixed_full_rate_group_o),
    .fixed_full_rate_group_oe_o(fixed_full_rate_group_oe_o),
    .switchable_group_high_o(switchable_group_high_o),
    .switchable_group_high_oe_o(switchable_group_high_oe_o)
);
`default_nettype wire

// >>> verification/clock_fanout_tb.sv
// self-checking bench for the clock fanout
`timescale 1ns/1ps
`default_nettype none
module clock_fanout_tb
    import clock_fanout_pkg::*;
;
    logic clock_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic in_clk = 1'b0;
    logic ref_o, ref_oe_o, drive_o;
    logic [7:0] paddr_i, fix_o, fix_oe;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] pstrb_i, low_o, low_oe, high_o, high_oe;
    int in_half = 4;
    int half_cnt = 0;
    int win_len = 64;
    int num_errors, n_compared;
    clock_fanout uut (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .crystal_or_clock_in_i(in_clk), .crystal_drive_out_o(drive_o), .ref_o(ref_o),
        .ref_oe_o(ref_oe_o), .switchable_group_low_o(low_o), .switchable_group_low_oe_o(low_oe),
        .fixed_full_rate_group_o(fix_o), .fixed_full_rate_group_oe_o(fix_oe),
        .switchable_group_high_o(high_o), .switchable_group_high_oe_o(high_oe));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // input half period in system cycles; the default of four lets the rates of codes 000, 001, 011 and 110 divide 64 cycles
    always @(posedge clock_i) begin
        if (half_cnt >= in_half - 1) begin
            half_cnt <= 0;
            in_clk <= ~in_clk;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            test_done();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // count rising edges of each group over a window after settling;
    // sampled on the falling edge where the registered outputs are settled
    task automatic measure(input logic [2:0] code, input logic [1:0] mode,
                           output int fr, output int lr, output int hr);
        logic pf, pl, ph;
        apb(1'b1, CTRL_OFFSET, {27'h0, code, mode});
        repeat (100) @(negedge clock_i);
        fr = 0;
        lr = 0;
        hr = 0;
        pf = fix_o[0];
        pl = low_o[0];
        ph = high_o[0];
        repeat (win_len) begin
            @(negedge clock_i);
            if (fix_o[0] === 1'b1 && pf === 1'b0) fr++;
            if (low_o[0] === 1'b1 && pl === 1'b0) lr++;
            if (high_o[0] === 1'b1 && ph === 1'b0) hr++;
            pf = fix_o[0];
            pl = low_o[0];
            ph = high_o[0];
        end
    endtask
    task automatic t_reset();
        check({15'h0, low_oe, fix_oe, high_oe, ref_oe_o}, 32'h0);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, {27'h0, RATIO_RESET, MODE_RESET});
        apb(1'b0, 8'h08, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    // divider-only ratio: full is input/2, half is input/4
    task automatic t_modes();
        int fr, lr, hr;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            measure(RATIO_DIVIDER_ONLY, m, fr, lr, hr);
            check({15'h0, low_oe, fix_oe, high_oe, ref_oe_o}, {15'h0, {17{m != 2'h0}}});
            check({31'h0, drive_o}, {31'h0, ~ref_o});
            if (m != 2'h0) begin
                check(32'(fr), 32'h4);
                check(32'(lr), m[0] ? 32'h4 : 32'h2);
                check(32'(hr), &m ? 32'h4 : 32'h2);
            end
        end
    endtask
    task automatic t_ratios();
        int fr, lr, hr;
        logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h3, 3'h6};
        int exp_r[4] = '{4, 8, 16, 32};
        for (int i = 0; i < 4; i++) begin
            measure(codes[i], MODE_ALL_FULL, fr, lr, hr);
            check(32'(fr), 32'(exp_r[i]));
            check(32'(hr), 32'(exp_r[i]));
        end
        // period of eight cycles comes from the bench's input clock
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check({15'h0, rd[16:0]}, {15'h0, 1'b1, 16'h0008});
    endtask
    // fractional ratios on a twenty cycle input: 48 cycles hold 2.4 input periods
    task automatic t_fractions();
        int fr, lr, hr;
        logic [2:0] codes[4] = '{3'h2, 3'h4, 3'h5, 3'h7};
        int exp_r[4] = '{3, 6, 8, 12};
        in_half = 10;
        win_len = 48;
        repeat (60) @(negedge clock_i);
        for (int i = 0; i < 4; i++) begin
            measure(codes[i], MODE_ALL_FULL, fr, lr, hr);
            check(32'(fr), 32'(exp_r[i]));
            check(32'(lr), 32'(exp_r[i]));
        end
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i} = '0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        resetn_i = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_modes();
        t_ratios();
        t_fractions();
        test_done();
    end
endmodule // clock_fanout_tb
`default_nettype wire
